// ### msd_pkg.sv
// Constants and types for the memory space decoder
package msd_pkg;
  // ==========================================
  // Program space
  localparam logic [15:0] msd_rom_last = 16'h1FFF;
  localparam logic [15:0] msd_reset_vector = 16'h0000;
  localparam logic [15:0] msd_init_last = 16'h0002;
  localparam logic [15:0] msd_irq_first = 16'h0003;
  localparam logic [15:0] msd_irq_last = 16'h0075;
  // ==========================================
  // Data space
  localparam logic [7:0] msd_bank_last = 8'h1F;
  localparam logic [7:0] msd_bit_first = 8'h20;
  localparam logic [7:0] msd_bit_last = 8'h2F;
  localparam logic [7:0] msd_sfr_first = 8'h80;
  localparam logic [7:0] msd_sp_reset = 8'h07;
  // ==========================================
  // Latch strobe timing
  localparam int msd_osc_per_strobe = 6;
  localparam logic [2:0] msd_strobe_last = 3'h5;
  localparam logic [2:0] msd_strobe_high_cycles = 3'h2;
  // ==========================================
  // Operating modes
  typedef enum logic [1:0] {msd_run, msd_idle, msd_powerdown} msd_mode_e;
  // Data space targets
  typedef enum logic [1:0] {msd_tgt_ram, msd_tgt_sfr} msd_target_e;
endpackage

// ### msd_strobe_gen.sv
// Address latch strobe generator
`timescale 1ns/1ps
module msd_strobe_gen (
  input wire logic clock,
  input wire logic rst,
  input wire logic skip,
  output logic strobe
);
  import msd_pkg::*;
  logic [2:0] phase;
  logic skip_pend;
  logic skip_now;
  // ==========================================
  // Six-period phase counter
  always_ff @(posedge clock) begin
    if (rst || phase == msd_strobe_last) begin
      phase <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
    end
  end
  // ==========================================
  // Skip request pending until period end
  always_ff @(posedge clock) begin
    if (rst) begin
      skip_pend <= 1'b0;
    end else if (phase == msd_strobe_last) begin
      skip_pend <= 1'b0;
    end else if (skip) begin
      skip_pend <= 1'b1;
    end
  end
  // Skip flag for the whole next period
  always_ff @(posedge clock) begin
    if (rst) begin
      skip_now <= 1'b0;
    end else if (phase == msd_strobe_last) begin
      skip_now <= skip_pend || skip;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      strobe <= 1'b0;
    end else begin
      strobe <= (phase < msd_strobe_high_cycles) && !skip_now;
    end
  end
endmodule

// ### msd_decoder.sv
// Memory space decoder top level
`timescale 1ns/1ps
// Function
// - Internal program storage covers the lowest 8K of 64K program space.
// - Fetch select high: internal below 8192, external from 8192 upward.
// - Fetch select low: every fetch goes external.
// - Fetch timing identical for internal and external code.
// - Last internal location may prefetch external 8192; software leaves 8191 unused.
// - Reset starts execution at 0000H; 0000H-0002H hold initialization code.
// - 0003H through 0075H are interrupt entry points for fifteen sources.
// - Internal data RAM spans bytes 0 through 255.
// - Four banks of eight registers occupy RAM 0 through 31.
// - Bytes 20H-2FH hold 128 bits; bit n is bit n mod 8 of 20H+n/8.
// - Stack anywhere in RAM through an 8-bit pointer, up to 256 deep.
// - Special function registers at direct addresses 128 through 255.
// - Idle: strobes high, port 0 floats if external; power-down: strobes low, port 2 data.
// - Latch strobe pulses every six periods, skipping one per external data access.
module msd_decoder (
  input wire logic clock,
  input wire logic rst,
  input wire logic external_fetch_select,
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_req,
  input wire logic [7:0] data_addr,
  input wire logic data_direct,
  input wire logic data_req,
  input wire logic [2:0] reg_index,
  input wire logic reg_req,
  input wire logic [6:0] bit_addr,
  input wire logic bit_req,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic sp_load,
  input wire logic [7:0] sp_value,
  input wire logic [7:0] program_status_word,
  input wire logic ext_data_access,
  input wire logic idle_enter,
  input wire logic powerdown_enter,
  input wire logic [7:0] port0_data,
  input wire logic [7:0] port2_data,
  input wire logic [15:0] ext_addr,
  output logic fetch_internal,
  output logic fetch_external,
  output logic [12:0] rom_addr,
  output logic [15:0] ext_fetch_addr,
  output logic fetch_reserved,
  output logic fetch_vector,
  output logic [7:0] ram_addr,
  output logic ram_sel,
  output logic sfr_sel,
  output logic [7:0] sfr_addr,
  output logic [2:0] bit_pos,
  output logic [7:0] stack_ptr,
  output logic [15:0] pc_start,
  output logic addr_latch_strobe,
  output logic program_read_strobe_n,
  output logic [7:0] port0_out,
  output logic port0_oe,
  output logic [7:0] port2_out,
  output logic modulation_output_zero,
  output logic modulation_output_one
);
  import msd_pkg::*;
  msd_mode_e mode;
  logic running_external;
  logic strobe_raw;
  logic [7:0] next_ram_addr;
  logic next_ram_sel;
  logic next_sfr_sel;
  logic [2:0] next_bit_pos;
  logic [1:0] bank_select;

  // ==========================================
  // Helpers
  function automatic logic is_internal(input logic sel, input logic [15:0] addr);
    is_internal = sel && (addr <= msd_rom_last);
  endfunction

  function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] idx);
    bank_addr = {3'h0, bank, idx};
  endfunction

  assign bank_select = program_status_word[4:3];

  // ==========================================
  // Program fetch routing
  always_ff @(posedge clock) begin
    if (rst) begin
      fetch_internal <= 1'b0;
      fetch_external <= 1'b0;
      rom_addr <= 13'h0000;
      ext_fetch_addr <= 16'h0000;
    end else begin
      // Same one-cycle latency on both paths
      fetch_internal <= fetch_req && is_internal(external_fetch_select, fetch_addr);
      fetch_external <= fetch_req && !is_internal(external_fetch_select, fetch_addr);
      rom_addr <= fetch_addr[12:0];
      ext_fetch_addr <= fetch_addr;
    end
  end

  // ==========================================
  // Reserved program locations
  always_ff @(posedge clock) begin
    if (rst) begin
      fetch_reserved <= 1'b0;
      fetch_vector <= 1'b0;
      pc_start <= msd_reset_vector;
    end else begin
      fetch_reserved <= fetch_req && (fetch_addr <= msd_init_last);
      fetch_vector <= fetch_req && (fetch_addr >= msd_irq_first) && (fetch_addr <= msd_irq_last);
      pc_start <= msd_reset_vector;
    end
  end

  // ==========================================
  // Data space decode
  always_comb begin
    next_ram_addr = 8'h00;
    next_ram_sel = 1'b0;
    next_sfr_sel = 1'b0;
    next_bit_pos = 3'h0;
    if (bit_req) begin
      next_ram_addr = msd_bit_first + {4'h0, bit_addr[6:3]};
      next_bit_pos = bit_addr[2:0];
      next_ram_sel = 1'b1;
    end else if (reg_req) begin
      next_ram_addr = bank_addr(bank_select, reg_index);
      next_ram_sel = 1'b1;
    end else if (data_req) begin
      next_ram_addr = data_addr;
      if (data_direct && data_addr >= msd_sfr_first) begin
        next_sfr_sel = 1'b1;
      end else begin
        next_ram_sel = 1'b1;
      end
    end else if (stack_push || stack_pop) begin
      next_ram_addr = stack_push ? stack_ptr + 8'h01 : stack_ptr;
      next_ram_sel = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ram_addr <= 8'h00;
      ram_sel <= 1'b0;
      sfr_sel <= 1'b0;
      sfr_addr <= 8'h00;
      bit_pos <= 3'h0;
    end else begin
      ram_addr <= next_ram_addr;
      ram_sel <= next_ram_sel;
      sfr_sel <= next_sfr_sel;
      sfr_addr <= next_sfr_sel ? data_addr : 8'h00;
      bit_pos <= next_bit_pos;
    end
  end

  // ==========================================
  // Stack pointer, wraps over all 256 bytes
  always_ff @(posedge clock) begin
    if (rst) begin
      stack_ptr <= msd_sp_reset;
    end else if (sp_load) begin
      stack_ptr <= sp_value;
    end else if (stack_push && !stack_pop) begin
      stack_ptr <= stack_ptr + 8'h01;
    end else if (stack_pop && !stack_push) begin
      stack_ptr <= stack_ptr - 8'h01;
    end
  end

  // ==========================================
  // Operating mode, left only by reset from power-down
  always_ff @(posedge clock) begin
    if (rst) begin
      mode <= msd_run;
    end else begin
      unique case (mode)
        msd_run: begin
          if (powerdown_enter) begin
            mode <= msd_powerdown;
          end else if (idle_enter) begin
            mode <= msd_idle;
          end
        end
        msd_idle: begin
          if (powerdown_enter) begin
            mode <= msd_powerdown;
          end
        end
        msd_powerdown: begin
          mode <= msd_powerdown;
        end
        default: begin
          mode <= msd_run;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      running_external <= 1'b0;
    end else if (mode == msd_run && fetch_req) begin
      running_external <= !is_internal(external_fetch_select, fetch_addr);
    end
  end

  msd_strobe_gen u_strobe (
    .clock(clock),
    .rst(rst),
    .skip(ext_data_access),
    .strobe(strobe_raw)
  );

  // ==========================================
  // Pin states
  always_ff @(posedge clock) begin
    if (rst) begin
      addr_latch_strobe <= 1'b0;
      program_read_strobe_n <= 1'b1;
    end else begin
      unique case (mode)
        msd_idle: begin
          addr_latch_strobe <= 1'b1;
          program_read_strobe_n <= 1'b1;
        end
        msd_powerdown: begin
          addr_latch_strobe <= 1'b0;
          program_read_strobe_n <= 1'b0;
        end
        default: begin
          addr_latch_strobe <= strobe_raw;
          program_read_strobe_n <= !(fetch_req && !is_internal(external_fetch_select, fetch_addr));
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      port0_out <= 8'h00;
      port0_oe <= 1'b0;
      port2_out <= 8'h00;
    end else begin
      port0_out <= port0_data;
      port0_oe <= !(mode != msd_run && running_external);
      if (mode == msd_idle && running_external) begin
        port2_out <= ext_addr[15:8];
      end else if (mode == msd_run && running_external) begin
        port2_out <= ext_addr[15:8];
      end else begin
        port2_out <= port2_data;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      modulation_output_zero <= 1'b1;
      modulation_output_one <= 1'b1;
    end else begin
      modulation_output_zero <= 1'b1;
      modulation_output_one <= 1'b1;
    end
  end
endmodule

// ### msd_decoder_properties.sv
// Port checker for the memory space decoder
`timescale 1ns/1ps
module msd_checker
  import msd_pkg::*;
(
  input wire logic clock, rst, external_fetch_select, fetch_req, data_direct, data_req,
  input wire logic reg_req, bit_req, stack_push, stack_pop, sp_load, powerdown_enter,
  input wire logic fetch_internal, fetch_external, fetch_vector, sfr_sel,
  input wire logic addr_latch_strobe, program_read_strobe_n,
  input wire logic modulation_output_zero, modulation_output_one,
  input wire logic [15:0] fetch_addr, ext_fetch_addr,
  input wire logic [12:0] rom_addr,
  input wire logic [7:0] data_addr, ram_addr, sfr_addr, stack_ptr, port2_data, port2_out,
  input wire logic [6:0] bit_addr,
  input wire logic [2:0] bit_pos
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================
  // Program space
  sequence s_int; fetch_req && external_fetch_select && fetch_addr <= msd_rom_last; endsequence
  sequence s_ext; fetch_req && (!external_fetch_select || fetch_addr > msd_rom_last); endsequence
  a_fetch_int: assert property (s_int |=> fetch_internal && rom_addr == $past(fetch_addr[12:0]))
    else $error("internal fetch wrong");
  a_fetch_ext: assert property (s_ext |=> fetch_external && ext_fetch_addr == $past(fetch_addr))
    else $error("external fetch wrong");
  a_irq_vector: assert property (fetch_req && fetch_addr inside {[msd_irq_first:msd_irq_last]} |=> fetch_vector)
    else $error("vector flag missing");
  // ==========================================
  // Data space
  a_bit_map: assert property (bit_req |=> ram_addr == msd_bit_first + $past(bit_addr[6:3]) && bit_pos == $past(bit_addr[2:0]))
    else $error("bit mapping wrong");
  a_sfr_direct: assert property (data_req && data_direct && data_addr >= msd_sfr_first && !bit_req && !reg_req
    |=> sfr_sel && sfr_addr == $past(data_addr))
    else $error("register space select wrong");
  a_stack_push: assert property (stack_push && !stack_pop && !sp_load |=> stack_ptr == $past(stack_ptr) + 8'h01)
    else $error("push pointer wrong");
  // ==========================================
  // Low power pins
  a_pd_pins: assert property (powerdown_enter |-> ##2 (!addr_latch_strobe && !program_read_strobe_n
    && port2_out == $past(port2_data)))
    else $error("power-down pins wrong");
  a_mod_high: assert property (modulation_output_zero && modulation_output_one)
    else $error("modulation output low");
endmodule
bind msd_decoder msd_checker u_chk (.*);

// ### msd_ext_mem.sv
// External program memory model on the far side
`timescale 1ns/1ps
module msd_ext_mem (
  input wire logic clock,
  input wire logic fetch_external,
  input wire logic [15:0] ext_fetch_addr,
  output logic [15:0] ext_addr,
  output int fetch_cnt
);
  initial fetch_cnt = 0;
  initial ext_addr = 16'h0000;
  // Latch each external fetch address
  always @(posedge clock) begin
    if (fetch_external === 1'b1) begin
      ext_addr <= ext_fetch_addr;
      fetch_cnt <= fetch_cnt + 1;
    end
  end
endmodule

// ### msd_testbench.sv
// Self-checking bench for the memory space decoder
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench;
  import msd_pkg::*;
  logic clock = 0, rst = 1, external_fetch_select = 1, fetch_req = 0, data_direct = 0, data_req = 0;
  logic reg_req = 0, bit_req = 0, stack_push = 0, stack_pop = 0, sp_load = 0, ext_data_access = 0;
  logic idle_enter = 0, powerdown_enter = 0;
  logic [15:0] fetch_addr = 16'h0000;
  logic [15:0] ext_addr, ext_fetch_addr, pc_start;
  logic [7:0] data_addr = 8'h00, sp_value = 8'h00, program_status_word = 8'h00;
  logic [7:0] port0_data = 8'h5A, port2_data = 8'hC3;
  logic [7:0] ram_addr, sfr_addr, stack_ptr, port0_out, port2_out;
  logic [2:0] reg_index = 3'h7, bit_pos;
  logic [6:0] bit_addr = 7'h00;
  logic [12:0] rom_addr;
  logic fetch_internal, fetch_external, fetch_reserved, fetch_vector, ram_sel, sfr_sel, port0_oe;
  logic addr_latch_strobe, program_read_strobe_n, modulation_output_zero, modulation_output_one;
  int error_cnt = 0, checks_done = 0, fetch_cnt, n;
  always #5 clock = ~clock;
  msd_decoder uut (.*);
  msd_ext_mem partner (.*);
  // ==========================================
  // Scenarios
  task automatic tick(int k = 1);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic t_reset();
    `CHK("stack_ptr", 8'h07, stack_ptr)
    `CHK("pc_start", 16'h0000, pc_start)
    `CHK("read_strobe_n", 1'b1, program_read_strobe_n)
  endtask
  task automatic t_fetch();
    logic [16:0] tab [6] = '{17'h11FFF, 17'h12000, 17'h00000, 17'h10003, 17'h10075, 17'h10002};
    logic e;
    foreach (tab[i]) begin
      {external_fetch_select, fetch_addr} = tab[i];
      fetch_req = 1;
      e = tab[i][16] && tab[i][15:0] < 16'h2000;
      tick();
      `CHK("internal", e, fetch_internal)
      `CHK("external", !e, fetch_external)
      if (e) `CHK("rom_addr", tab[i][12:0], rom_addr)
      `CHK("vector", tab[i][15:0] inside {[16'h0003:16'h0075]}, fetch_vector)
      `CHK("reserved", tab[i][15:0] <= 16'h0002, fetch_reserved)
    end
    fetch_req = 0;
    tick();
    `CHK("ext_count", 2, fetch_cnt)
  endtask
  task automatic t_data();
    data_req = 1;
    data_addr = 8'h80;
    for (n = 0; n < 2; n++) begin
      data_direct = n[0];
      tick();
      `CHK("sfr_sel", n[0], sfr_sel)
      `CHK("ram_sel", !n[0], ram_sel)
    end
    data_addr = 8'hFF;
    data_direct = 0;
    bit_req = 1;
    for (n = 0; n < 2; n++) begin
      bit_addr = n[0] ? 7'h7F : 7'h00;
      tick();
      `CHK("bit_byte", n[0] ? 8'h2F : 8'h20, ram_addr)
      `CHK("bit_pos", n[0] ? 3'h7 : 3'h0, bit_pos)
    end
    bit_req = 0;
    data_req = 0;
    reg_req = 1;
    for (n = 0; n < 4; n++) begin
      program_status_word = 8'(n << 3);
      tick();
      `CHK("bank_reg", 8'(8 * n + 7), ram_addr)
    end
    reg_req = 0;
  endtask
  task automatic t_stack();
    sp_load = 1;
    sp_value = 8'hFF;
    tick();
    sp_load = 0;
    stack_push = 1;
    tick();
    stack_push = 0;
    `CHK("push_wrap", 8'h00, stack_ptr)
    stack_pop = 1;
    tick();
    stack_pop = 0;
    `CHK("pop_wrap", 8'hFF, stack_ptr)
  endtask
  task automatic t_strobe();
    int c;
    for (n = 0; n < 2; n++) begin
      c = 0;
      while (addr_latch_strobe === 1'b1) tick();
      ext_data_access = n[0];
      repeat (24) begin
        tick();
        ext_data_access = 0;
        c += addr_latch_strobe;
      end
      `CHK("strobe_highs", 8 - 2 * n, c)
    end
  endtask
  task automatic t_low_power();
    external_fetch_select = 0;
    fetch_addr = 16'hA55A;
    fetch_req = 1;
    tick();
    fetch_req = 0;
    idle_enter = 1;
    tick(2);
    idle_enter = 0;
    `CHK("idle_strobes", 2'b11, {addr_latch_strobe, program_read_strobe_n})
    `CHK("idle_p0_oe", 1'b0, port0_oe)
    `CHK("idle_p2", 8'hA5, port2_out)
    `CHK("idle_p0_data", 8'h5A, port0_out)
    rst = 1;
    tick(2);
    rst = 0;
    powerdown_enter = 1;
    tick();
    powerdown_enter = 0;
    tick();
    `CHK("pd_strobes", 2'b00, {addr_latch_strobe, program_read_strobe_n})
    `CHK("pd_p2", 8'hC3, port2_out)
    `CHK("pwm_high", 2'b11, {modulation_output_zero, modulation_output_one})
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    tick(10);
    rst = 0;
    t_reset();
    t_fetch();
    t_data();
    t_stack();
    t_strobe();
    t_low_power();
    give_verdict();
  end
  initial begin
    #20000;
    error_cnt++;
    give_verdict();
  end
endmodule
